// [src/acc_exec_pkg.sv]
`default_nettype none
package acc_exec_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_VALUE = 8'h08;
   localparam logic [7:0] OFS_ACC = 8'h0C;
   localparam logic [7:0] OFS_REPLY_STATUS = 8'h10;
   localparam logic [7:0] OFS_REPLY_VALUE = 8'h14;
   localparam logic [7:0] OFS_PC = 8'h18;
   localparam logic [7:0] OFS_FLAGS = 8'h1C;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
   // Control fields
   localparam int CTRL_STANDALONE = 0;
   localparam int CTRL_ADDR_LSB = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
   // Command word fields
   localparam int CMD_INSTR_LSB = 0;
   localparam int CMD_TYPE_LSB = 8;
   localparam int CMD_BANK_LSB = 16;
   localparam int CMD_CSUM_LSB = 24;
   // Instruction numbers
   localparam logic [7:0] INSTR_READ_INPUT = 8'h0F;
   localparam logic [7:0] INSTR_ACCUMULATE = 8'h13;
   localparam logic [7:0] INSTR_COMPARE = 8'h14;
   localparam logic [7:0] INSTR_JUMP_COND = 8'h15;
   // accumulate_op types
   localparam logic [7:0] ACC_ADD = 8'h00;
   localparam logic [7:0] ACC_SUB = 8'h01;
   localparam logic [7:0] ACC_MUL = 8'h02;
   localparam logic [7:0] ACC_DIV = 8'h03;
   localparam logic [7:0] ACC_MOD = 8'h04;
   localparam logic [7:0] ACC_AND = 8'h05;
   localparam logic [7:0] ACC_OR = 8'h06;
   localparam logic [7:0] ACC_XOR = 8'h07;
   localparam logic [7:0] ACC_NOT = 8'h08;
   localparam logic [7:0] ACC_LOAD = 8'h09;
   // conditional_jump: types 0..11 index the condition vector
   localparam logic [7:0] JUMP_TYPE_COUNT = 8'h0C;
   // read_input_cmd banks and ports
   localparam logic [7:0] BANK_INPUTS = 8'h00;
   localparam logic [7:0] BANK_OUTPUTS = 8'h02;
   localparam logic [7:0] PORT_COUNT = 8'h04;
   localparam logic [7:0] PORT_ENABLE = 8'h0A;
   localparam logic [7:0] PORT_ALL = 8'hFF;
   // Reply status codes
   localparam logic [7:0] STAT_OK = 8'h64;
   localparam logic [7:0] STAT_BAD_CSUM = 8'h01;
   localparam logic [7:0] STAT_BAD_CMD = 8'h02;
   localparam logic [7:0] STAT_BAD_TYPE = 8'h03;
   localparam logic [7:0] STAT_BAD_VALUE = 8'h04;
   localparam logic [7:0] STAT_PROGRAM_ONLY = 8'h06;
   // Interrupt status bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_CSUM = 1;
   localparam int IRQ_JUMP = 2;
   localparam int IRQ_WIDTH = 3;
   // Flag register bits
   localparam int FLAG_EQ = 0;
   localparam int FLAG_GT = 1;
   localparam int FLAG_LT = 2;
endpackage : acc_exec_pkg
`default_nettype wire

// [src/acc_alu.sv]
`timescale 1ns/1ns
`default_nettype none
module acc_alu (
   // Operands
   input wire logic [31:0] acc,
   input wire logic [31:0] operand,
   input wire logic [7:0] op,
   // Result
   output logic [31:0] result,
   output logic typeOk,
   output logic divOk
);
   wire logic divide = (op == acc_exec_pkg::ACC_DIV) || (op == acc_exec_pkg::ACC_MOD);
   // Signed operands, as the values travel two's complement
   wire logic signed [31:0] sa = $signed(acc);
   wire logic signed [31:0] sb = $signed(operand);
   // Zero divisor is caught; result would be meaningless
   wire logic signed [31:0] safeB = (operand == 32'h0000_0000) ? 32'sh0000_0001 : sb;
   wire logic signed [31:0] quot = sa / safeB;
   wire logic signed [31:0] rem = sa % safeB;
   wire logic signed [31:0] prod = sa * sb;

   assign divOk = !divide || (operand != 32'h0000_0000);
   assign typeOk = op <= acc_exec_pkg::ACC_LOAD;
   assign result =
      (op == acc_exec_pkg::ACC_ADD) ? acc + operand :
      (op == acc_exec_pkg::ACC_SUB) ? acc - operand :
      (op == acc_exec_pkg::ACC_MUL) ? prod :
      (op == acc_exec_pkg::ACC_DIV) ? quot :
      (op == acc_exec_pkg::ACC_MOD) ? rem :
      (op == acc_exec_pkg::ACC_AND) ? acc & operand :
      (op == acc_exec_pkg::ACC_OR) ? acc | operand :
      (op == acc_exec_pkg::ACC_XOR) ? acc ^ operand :
      (op == acc_exec_pkg::ACC_NOT) ? ~acc :
      (op == acc_exec_pkg::ACC_LOAD) ? operand : acc;
endmodule : acc_alu
`default_nettype wire

// [src/acc_exec.sv]
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module acc_exec #(
   parameter int PC_WIDTH = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Digital lines
   input wire logic [3:0] digIn,
   input wire logic [3:0] outState,
   input wire logic moduleEnable,
   // Error flags from the motion side
   input wire logic timeoutErr,
   input wire logic alarmErr,
   input wire logic deviationErr,
   input wire logic positionErr,
   // Interrupt and program counter
   output logic irq,
   output logic [PC_WIDTH-1:0] pc
);
   function automatic logic [7:0] byteSum(input logic [31:0] w);
      byteSum = w[31:24] + w[23:16] + w[15:8] + w[7:0];
   endfunction : byteSum

   localparam int IRQ_WIDTH_L = acc_exec_pkg::IRQ_WIDTH;

   // Bus phase tracking
   logic dpValid;
   logic dpWrite;
   logic [7:0] dpAddr;
   logic rdReady;
   // Registers
   logic [31:0] ctrl;
   logic [31:0] valueReg;
   logic [7:0] cmdInstr;
   logic [7:0] cmdType;
   logic [7:0] cmdBank;
   logic [7:0] cmdCsum;
   logic cmdGo;
   logic [31:0] acc;
   logic [7:0] replyStatus;
   logic [7:0] replyInstr;
   logic [31:0] replyValue;
   logic flagEq;
   logic flagGt;
   logic flagLt;
   logic [IRQ_WIDTH_L-1:0] irqStatus;
   logic [IRQ_WIDTH_L-1:0] irqMask;

   // AHB decode
   wire logic take = hsel && htrans[1] && hready;
   wire logic rdLoad = dpValid && !dpWrite && !rdReady;
   wire logic wrEn = dpValid && dpWrite;
   wire logic wrCtrl = wrEn && (dpAddr == acc_exec_pkg::OFS_CTRL);
   wire logic wrCmd = wrEn && (dpAddr == acc_exec_pkg::OFS_CMD);
   wire logic wrValue = wrEn && (dpAddr == acc_exec_pkg::OFS_VALUE);
   wire logic wrMask = wrEn && (dpAddr == acc_exec_pkg::OFS_IRQ_MASK);
   wire logic rdIrq = rdLoad && (dpAddr == acc_exec_pkg::OFS_IRQ_STATUS);

   // Reads take one wait state so hrdata comes from a flop
   assign hreadyout = !rdLoad;
   assign hresp = 1'b0;

   wire logic standalone = ctrl[acc_exec_pkg::CTRL_STANDALONE];
   wire logic [7:0] targetAddr = ctrl[acc_exec_pkg::CTRL_ADDR_LSB +: 8];

   // Frame check over address, instruction, type, bank, value bytes
   wire logic [7:0] frameSum = targetAddr + cmdInstr + cmdType + cmdBank + byteSum(valueReg);
   wire logic csumOk = frameSum == cmdCsum;

   wire logic isRead = cmdInstr == acc_exec_pkg::INSTR_READ_INPUT;
   wire logic isAcc = cmdInstr == acc_exec_pkg::INSTR_ACCUMULATE;
   wire logic isCmp = cmdInstr == acc_exec_pkg::INSTR_COMPARE;
   wire logic isJmp = cmdInstr == acc_exec_pkg::INSTR_JUMP_COND;

   // Accumulator arithmetic
   logic [31:0] aluResult;
   logic aluTypeOk;
   logic aluDivOk;
   acc_alu u_alu (
      .acc(acc),
      .operand(valueReg),
      .op(cmdType),
      .result(aluResult),
      .typeOk(aluTypeOk),
      .divOk(aluDivOk)
   );

   // read_input_cmd port selection
   wire logic inBank0 = cmdBank == acc_exec_pkg::BANK_INPUTS;
   wire logic inBank2 = cmdBank == acc_exec_pkg::BANK_OUTPUTS;
   wire logic lowPort = cmdType < acc_exec_pkg::PORT_COUNT;
   wire logic allPort = cmdType == acc_exec_pkg::PORT_ALL;
   wire logic enPort = inBank0 && (cmdType == acc_exec_pkg::PORT_ENABLE);
   wire logic readOk = (inBank0 && (lowPort || allPort)) || enPort || (inBank2 && (lowPort || allPort));
   wire logic [3:0] lineSet = inBank2 ? outState : digIn;
   wire logic [31:0] readValue =
      enPort ? {31'h0000_0000, !moduleEnable} :
      allPort ? {28'h000_0000, lineSet} :
      {31'h0000_0000, lineSet[cmdType[1:0]]};

   // Compare of accumulator against operand
   wire logic nextEq = acc == valueReg;
   wire logic nextGt = $signed(acc) > $signed(valueReg);
   wire logic nextLt = $signed(acc) < $signed(valueReg);

   // Conditions read the stored flags, never the live accumulator
   wire logic [11:0] condVec = {
      positionErr,
      deviationErr,
      alarmErr,
      timeoutErr,
      flagLt || flagEq,
      flagLt,
      flagGt || flagEq,
      flagGt,
      !flagEq,
      flagEq,
      !flagEq,
      flagEq
   };
   wire logic jmpTypeOk = cmdType < acc_exec_pkg::JUMP_TYPE_COUNT;
   wire logic condMet = jmpTypeOk && condVec[cmdType[3:0]];

   // Compare and jump are refused from the host in direct mode
   wire logic programOnly = (isCmp || isJmp) && !standalone;

   wire logic [7:0] nextStatus =
      !csumOk ? acc_exec_pkg::STAT_BAD_CSUM :
      programOnly ? acc_exec_pkg::STAT_PROGRAM_ONLY :
      isAcc ? (!aluTypeOk ? acc_exec_pkg::STAT_BAD_TYPE :
               !aluDivOk ? acc_exec_pkg::STAT_BAD_VALUE : acc_exec_pkg::STAT_OK) :
      isRead ? (readOk ? acc_exec_pkg::STAT_OK : acc_exec_pkg::STAT_BAD_VALUE) :
      isCmp ? acc_exec_pkg::STAT_OK :
      isJmp ? (jmpTypeOk ? acc_exec_pkg::STAT_OK : acc_exec_pkg::STAT_BAD_TYPE) :
      acc_exec_pkg::STAT_BAD_CMD;
   wire logic execOk = cmdGo && (nextStatus == acc_exec_pkg::STAT_OK);
   wire logic jumpTaken = execOk && isJmp && condMet;

   // Accumulator: direct mode host may use it and sees the echo
   wire logic [31:0] next_acc =
      (execOk && isAcc) ? aluResult :
      (execOk && isRead && standalone) ? readValue : acc;
   wire logic [31:0] next_replyValue = isRead ? readValue : valueReg;

   // Only standalone execution advances the program counter
   wire logic [PC_WIDTH-1:0] next_pc =
      jumpTaken ? valueReg[PC_WIDTH-1:0] :
      (cmdGo && standalone) ? pc + 1'b1 : pc;

   wire logic [IRQ_WIDTH_L-1:0] irqEvents = {jumpTaken, cmdGo && !csumOk, cmdGo};
   // Events set in the read-clear cycle survive
   wire logic [IRQ_WIDTH_L-1:0] next_irqStatus = (rdIrq ? '0 : irqStatus) | irqEvents;

   wire logic [31:0] regRead =
      (dpAddr == acc_exec_pkg::OFS_CTRL) ? ctrl :
      (dpAddr == acc_exec_pkg::OFS_CMD) ? {cmdCsum, cmdBank, cmdType, cmdInstr} :
      (dpAddr == acc_exec_pkg::OFS_VALUE) ? valueReg :
      (dpAddr == acc_exec_pkg::OFS_ACC) ? acc :
      (dpAddr == acc_exec_pkg::OFS_REPLY_STATUS) ? {16'h0000, replyInstr, replyStatus} :
      (dpAddr == acc_exec_pkg::OFS_REPLY_VALUE) ? replyValue :
      (dpAddr == acc_exec_pkg::OFS_PC) ? 32'(pc) :
      (dpAddr == acc_exec_pkg::OFS_FLAGS) ? {25'h000_0000, timeoutErr, alarmErr, deviationErr, positionErr,
         flagLt, flagGt, flagEq} :
      (dpAddr == acc_exec_pkg::OFS_IRQ_STATUS) ? 32'(irqStatus) :
      (dpAddr == acc_exec_pkg::OFS_IRQ_MASK) ? 32'(irqMask) : 32'h0000_0000;

   assign irq = |(irqStatus & irqMask);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         dpValid <= 1'b0;
      end else if (hready) begin
         dpValid <= take;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         dpWrite <= 1'b0;
         dpAddr <= 8'h00;
      end else if (hready) begin
         dpWrite <= hwrite;
         dpAddr <= haddr[7:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rdReady <= 1'b0;
      end else begin
         rdReady <= rdLoad;
      end
   end

   // Read data holds until the next read
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         hrdata <= 32'h0000_0000;
      end else if (rdLoad) begin
         hrdata <= regRead;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctrl <= acc_exec_pkg::CTRL_RESET;
      end else if (wrCtrl) begin
         ctrl <= hwdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         valueReg <= 32'h0000_0000;
      end else if (wrValue) begin
         valueReg <= hwdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irqMask <= '0;
      end else if (wrMask) begin
         irqMask <= hwdata[IRQ_WIDTH_L-1:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cmdInstr <= 8'h00;
         cmdType <= 8'h00;
         cmdBank <= 8'h00;
         cmdCsum <= 8'h00;
         cmdGo <= 1'b0;
      end else begin
         cmdGo <= wrCmd;
         if (wrCmd) begin
            cmdInstr <= hwdata[acc_exec_pkg::CMD_INSTR_LSB +: 8];
            cmdType <= hwdata[acc_exec_pkg::CMD_TYPE_LSB +: 8];
            cmdBank <= hwdata[acc_exec_pkg::CMD_BANK_LSB +: 8];
            cmdCsum <= hwdata[acc_exec_pkg::CMD_CSUM_LSB +: 8];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         acc <= 32'h0000_0000;
      end else begin
         acc <= next_acc;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pc <= '0;
      end else begin
         pc <= next_pc;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irqStatus <= '0;
      end else begin
         irqStatus <= next_irqStatus;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         replyStatus <= 8'h00;
         replyInstr <= 8'h00;
      end else if (cmdGo) begin
         replyStatus <= nextStatus;
         replyInstr <= cmdInstr;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         replyValue <= 32'h0000_0000;
      end else if (cmdGo) begin
         replyValue <= next_replyValue;
      end
   end

   // Flags change only on a successful compare
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         flagEq <= 1'b0;
         flagGt <= 1'b0;
         flagLt <= 1'b0;
      end else if (execOk && isCmp) begin
         flagEq <= nextEq;
         flagGt <= nextGt;
         flagLt <= nextLt;
      end
   end
endmodule : acc_exec
`default_nettype wire

// [tb/acc_exec_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module acc_exec_assertions #(
   parameter int PC_WIDTH = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Error flags and program counter
   input wire logic timeoutErr,
   input wire logic alarmErr,
   input wire logic deviationErr,
   input wire logic positionErr,
   input wire logic [PC_WIDTH-1:0] pc
);
   logic wrPend;
   logic [7:0] wrAddr;
   logic [31:0] ctrl;
   logic [31:0] val;
   wire logic take = hsel & htrans[1] & hready;
   wire logic rdTake = take & ~hwrite;
   wire logic wrData = wrPend & hready;
   wire logic cmdWr = wrData & (wrAddr == acc_exec_pkg::OFS_CMD);
   wire logic [7:0] sum = ctrl[15:8] + hwdata[7:0] + hwdata[15:8] + hwdata[23:16] + val[31:24] + val[23:16]
      + val[15:8] + val[7:0];
   wire logic isJump = hwdata[7:0] == acc_exec_pkg::INSTR_JUMP_COND;
   // Only error-flag jumps are predictable from the pins alone
   wire logic errJump = cmdWr & ctrl[0] & isJump & (sum == hwdata[31:24]) & (hwdata[15:10] == 6'h02);
   wire logic [3:0] errVec = {positionErr, deviationErr, alarmErr, timeoutErr};
   wire logic errHit = errVec[hwdata[9:8]];
   wire logic [PC_WIDTH-1:0] target = val[PC_WIDTH-1:0];
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wrPend <= 1'b0;
         wrAddr <= 8'h00;
         ctrl <= acc_exec_pkg::CTRL_RESET;
         val <= 32'h0000_0000;
      end else begin
         if (hready) begin
            wrPend <= take & hwrite;
            wrAddr <= haddr[7:0];
         end
         if (wrData && wrAddr == acc_exec_pkg::OFS_CTRL) begin
            ctrl <= hwdata;
         end
         if (wrData && wrAddr == acc_exec_pkg::OFS_VALUE) begin
            val <= hwdata;
         end
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   sequence s_wait_state;
      !hreadyout ##1 hreadyout;
   endsequence
   property p_read_wait;
      rdTake |=> s_wait_state;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
   property p_okay;
      hresp == 1'b0;
   endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   property p_wait_only_read;
      !hreadyout |-> $past(rdTake);
   endproperty
   a_wait_only_read: assert property (p_wait_only_read) else $error("stray wait state");
   property p_rdata_hold;
      $changed(hrdata) |-> $past(rdTake, 2);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_pc_direct;
      !ctrl[0] && !$past(srst) |-> $stable(pc);
   endproperty
   a_pc_direct: assert property (p_pc_direct) else $error("pc moved in direct mode");
   property p_advance;
      cmdWr && ctrl[0] && !isJump |-> ##2 pc == $past(pc, 2) + 1'b1;
   endproperty
   a_advance: assert property (p_advance) else $error("pc did not advance");
   property p_err_taken;
      errJump && errHit |-> ##2 pc == target;
   endproperty
   a_err_taken: assert property (p_err_taken) else $error("error jump not taken");
   property p_err_skip;
      errJump && !errHit |-> ##2 pc == $past(pc, 2) + 1'b1;
   endproperty
   a_err_skip: assert property (p_err_skip) else $error("error jump taken wrongly");
endmodule : acc_exec_assertions
bind acc_exec acc_exec_assertions #(.PC_WIDTH(PC_WIDTH)) i_acc_exec_assertions (.clk_sys(clk_sys),
   .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timeoutErr(timeoutErr),
   .alarmErr(alarmErr), .deviationErr(deviationErr), .positionErr(positionErr), .pc(pc));
`default_nettype wire

// [tb/host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module host_model (
   // Clock
   input wire logic clk_sys,
   // Bus master
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // Slave never answered
   output logic timedOut
);
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata, timedOut} = '0;
      hsize = 3'h2;
   end
   task automatic phase(output logic [31:0] rd);
      int k;
      logic r;
      k = 0;
      do begin
         @(negedge clk_sys);
         r = hready;
         rd = hrdata;
         k++;
         @(posedge clk_sys);
      end while (r !== 1'b1 && k < 40);
      if (r !== 1'b1) timedOut <= 1'b1;
   endtask : phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      phase(rd);
      htrans <= 2'h0;
      hwdata <= wd;
      phase(rd);
      hsel <= 1'b0;
   endtask : xfer
   // Target address stays 1; bad inverts the checksum
   task automatic send(input logic [7:0] ins, input logic [7:0] ty, input logic [7:0] bk, input logic [31:0] v,
      input logic bad);
      logic [7:0] cs;
      logic [31:0] rd;
      cs = 8'h01 + ins + ty + bk + v[31:24] + v[23:16] + v[15:8] + v[7:0];
      xfer(1'b1, acc_exec_pkg::OFS_VALUE, v, rd);
      xfer(1'b1, acc_exec_pkg::OFS_CMD, {cs ^ {8{bad}}, bk, ty, ins}, rd);
   endtask : send
endmodule : host_model
`default_nettype wire

// [tb/tb_accumulator_compare_jump.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_accumulator_compare_jump;
   logic clk_sys, srst, hsel, hwrite, hreadyout, hresp, irq, timedOut, moduleEnable, stand;
   logic [31:0] haddr, hwdata, hrdata, rd, accExp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] digIn, outState, errVec;
   logic [15:0] pc, pcExp;
   int errors, n_tests;
   initial clk_sys = 1'b0;
   always #20 clk_sys = ~clk_sys;
   acc_exec #(.PC_WIDTH(16)) i_acc_exec (.clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .digIn(digIn), .outState(outState),
      .moduleEnable(moduleEnable), .timeoutErr(errVec[0]), .alarmErr(errVec[1]),
      .deviationErr(errVec[2]), .positionErr(errVec[3]), .irq(irq), .pc(pc));
   host_model i_host_model (.clk_sys(clk_sys), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .timedOut(timedOut));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic rdreg(input logic [7:0] a);
      i_host_model.xfer(1'b0, a, 32'h0000_0000, rd);
   endtask : rdreg
   task automatic run(input logic [7:0] ins, input logic [7:0] ty, input logic [7:0] bk, input logic [31:0] v);
      i_host_model.send(ins, ty, bk, v, 1'b0);
      pcExp = pcExp + stand;
   endtask : run
   task automatic status(input logic [7:0] exp);
      rdreg(acc_exec_pkg::OFS_REPLY_STATUS);
      chk("reply status", {24'h00_0000, exp}, {24'h00_0000, rd[7:0]});
   endtask : status
   task automatic jump(input logic [7:0] t, input logic taken);
      run(acc_exec_pkg::INSTR_JUMP_COND, t, 8'h00, {24'h00_0000, t} + 32'h0000_0040);
      if (taken) pcExp = {8'h00, t} + 16'h0040;
      // Counter moves one edge after the command strobe
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk("program counter", {16'h0000, pcExp}, {16'h0000, pc});
      @(posedge clk_sys);
   endtask : jump
   function automatic logic [31:0] arithModel(input logic [7:0] t, input logic [31:0] a, input logic [31:0] b);
      case (t)
         8'h00: return a + b;
         8'h01: return a - b;
         8'h02: return a * b;
         8'h03: return $signed(a) / $signed(b);
         8'h04: return $signed(a) % $signed(b);
         8'h05: return a & b;
         8'h06: return a | b;
         8'h07: return a ^ b;
         8'h08: return ~a;
         default: return b;
      endcase
   endfunction : arithModel
   function automatic logic cond(input int t, input logic [31:0] a, input logic [31:0] b);
      logic eq, gt;
      eq = a == b;
      gt = $signed(a) > $signed(b);
      case (t)
         0, 2: return eq;
         1, 3: return !eq;
         4: return gt;
         5: return gt | eq;
         6: return !(gt | eq);
         default: return !gt;
      endcase
   endfunction : cond
   task automatic s_read_io;
      outState <= 4'hA;
      for (int p = 0; p < 5; p++) begin
         moduleEnable <= p[0];
         run(acc_exec_pkg::INSTR_READ_INPUT, 8'(p), acc_exec_pkg::BANK_OUTPUTS, 32'h0000_0000);
         rdreg(acc_exec_pkg::OFS_REPLY_VALUE);
         if (p < 4) chk("output state", {31'h0, outState[p]}, rd);
         run(acc_exec_pkg::INSTR_READ_INPUT, acc_exec_pkg::PORT_ENABLE, acc_exec_pkg::BANK_INPUTS, 32'h0000_0000);
         rdreg(acc_exec_pkg::OFS_REPLY_VALUE);
         chk("enable state", {31'h0, ~p[0]}, rd);
      end
      rdreg(acc_exec_pkg::OFS_ACC);
      chk("acc after direct read", 32'h0000_0000, rd);
   endtask : s_read_io
   task automatic s_arith;
      logic [31:0] ops [10];
      logic [7:0] t;
      ops = '{32'h0000_0014, 32'h0000_001E, 32'hFFFF_FFFD, 32'hFFFF_FFFC, 32'h0000_0005, 32'h0000_00FF,
         32'h0000_0100, 32'h0000_00F0, 32'h0000_0055, 32'hFFFF_FFF9};
      for (int i = 0; i < 10; i++) begin
         t = 8'((i + 9) % 10);
         run(acc_exec_pkg::INSTR_ACCUMULATE, t, 8'h00, ops[t]);
         accExp = arithModel(t, accExp, ops[t]);
         rdreg(acc_exec_pkg::OFS_ACC);
         chk("acc result", accExp, rd);
         status(acc_exec_pkg::STAT_OK);
         rdreg(acc_exec_pkg::OFS_REPLY_VALUE);
         chk("echoed operand", ops[t], rd);
      end
      run(acc_exec_pkg::INSTR_ACCUMULATE, acc_exec_pkg::ACC_DIV, 8'h00, 32'h0000_0000);
      status(acc_exec_pkg::STAT_BAD_VALUE);
   endtask : s_arith
   task automatic s_faults;
      i_host_model.xfer(1'b1, acc_exec_pkg::OFS_IRQ_MASK, 32'h0000_0002, rd);
      i_host_model.send(acc_exec_pkg::INSTR_ACCUMULATE, acc_exec_pkg::ACC_LOAD, 8'h00, 32'h0000_1234, 1'b1);
      status(acc_exec_pkg::STAT_BAD_CSUM);
      @(negedge clk_sys);
      chk("irq raised", 32'h1, {31'h0, irq});
      rdreg(acc_exec_pkg::OFS_IRQ_STATUS);
      chk("irq status", 32'h0000_0003, rd);
      run(acc_exec_pkg::INSTR_COMPARE, 8'h00, 8'h00, 32'h0000_0001);
      status(acc_exec_pkg::STAT_PROGRAM_ONLY);
      @(negedge clk_sys);
      chk("masked irq", 32'h0, {31'h0, irq});
      rdreg(acc_exec_pkg::OFS_ACC);
      chk("acc kept", accExp, rd);
      rdreg(8'h30);
      chk("unmapped read", 32'h0000_0000, rd);
   endtask : s_faults
   task automatic s_program;
      logic [31:0] cmp [3];
      logic [3:0] e;
      cmp = '{32'h0000_000F, 32'h0000_0014, 32'hFFFF_FFFF};
      i_host_model.xfer(1'b1, acc_exec_pkg::OFS_CTRL, 32'h0000_0101, rd);
      stand = 1'b1;
      accExp = 32'h0000_000F;
      run(acc_exec_pkg::INSTR_ACCUMULATE, acc_exec_pkg::ACC_LOAD, 8'h00, accExp);
      for (int c = 0; c < 3; c++) begin
         run(acc_exec_pkg::INSTR_COMPARE, 8'h00, 8'h00, cmp[c]);
         for (int t = 0; t < 8; t++) jump(8'(t), cond(t, accExp, cmp[c]));
      end
      run(acc_exec_pkg::INSTR_ACCUMULATE, acc_exec_pkg::ACC_LOAD, 8'h00, 32'hFFFF_FFFF);
      jump(8'h02, 1'b0);
      jump(8'h04, 1'b1);
      for (int k = 0; k < 2; k++) begin
         e = k ? 4'hA : 4'h5;
         errVec <= e;
         for (int i = 0; i < 4; i++) jump(8'(i + 8), e[i]);
      end
      errVec <= 4'h0;
      digIn <= 4'h6;
      run(acc_exec_pkg::INSTR_READ_INPUT, acc_exec_pkg::PORT_ALL, acc_exec_pkg::BANK_INPUTS, 32'h0000_0000);
      rdreg(acc_exec_pkg::OFS_ACC);
      chk("acc after program read", 32'h0000_0006, rd);
      rdreg(acc_exec_pkg::OFS_IRQ_STATUS);
      chk("jump event", 32'h0000_0005, rd);
      i_host_model.xfer(1'b1, acc_exec_pkg::OFS_CTRL, 32'h0000_0100, rd);
   endtask : s_program
   task automatic end_of_test;
      if (errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   always @(posedge timedOut) begin
      errors++;
      end_of_test;
   end
   initial begin
      {srst, moduleEnable, stand, digIn, outState, errVec, pcExp, accExp} = '0;
      srst = 1'b1;
      errors = 0;
      n_tests = 0;
      repeat (4) @(posedge clk_sys);
      srst <= 1'b0;
      s_read_io;
      s_arith;
      s_faults;
      s_program;
      end_of_test;
   end
endmodule : tb_accumulator_compare_jump
`default_nettype wire
